//--- rme_pkg.sv
package rme_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [9:0] A_DUR_LO = 10'h150;
   localparam logic [9:0] A_DUR_HI = 10'h151;
   localparam logic [9:0] A_MULT0  = 10'h152;
   localparam logic [9:0] A_MULT3  = 10'h155;
   localparam logic [9:0] A_DELAY  = 10'h156;
   localparam logic [9:0] A_WAIT   = 10'h157;
   localparam logic [9:0] A_CFG    = 10'h158;
   localparam logic [9:0] A_EXT_HI = 10'h159;
   localparam logic [9:0] A_EXT_LO = 10'h15a;
   localparam logic [9:0] A_FIR    = 10'h15b;
   localparam logic [9:0] A_MAXIDX = 10'h15c;
   localparam logic [9:0] A_PKWAIT = 10'h15e;
   localparam logic [9:0] A_PRE    = 10'h1a7;
   localparam logic [9:0] A_SYM    = 10'h1a8;
   localparam logic [9:0] A_LSB    = 10'h1a9;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CFG_POW2 = 0;
   localparam int CFG_SEL  = 2;
   localparam int CFG_TRIG = 5;
   localparam int FIR_SEL  = 0;
   localparam int FIR_LNA1 = 4;
   localparam int FIR_LNA2 = 5;
   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [7:0] CFG_RST    = 8'h01;
   localparam logic [7:0] MAXIDX_RST = 8'h76;
   localparam logic [7:0] W_FULL     = 8'hff;
   localparam logic [7:0] W_NONE     = 8'h00;
   localparam int         DELAY_DIV  = 8;
   localparam logic [2:0] SEL_AGC    = 3'h0;
   localparam logic [2:0] SEL_PIN    = 3'h1;
   localparam logic [2:0] SEL_RX     = 3'h2;
   localparam logic [2:0] SEL_GAIN   = 3'h3;
   localparam logic [2:0] SEL_WR     = 3'h4;
   localparam logic [2:0] SEL_GPIN   = 3'h5;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_DELAY, ST_MEAS, ST_WAIT} rme_state_e;
   typedef struct packed {
      logic [6:0] index;
      logic       cal_flag;
      logic [3:0] front_stage;
      logic [1:0] ext_lna;
   } rme_gt_s;
   typedef struct packed {
      logic [8:0] pre;
      logic [8:0] sym;
   } rme_result_s;
endpackage

//--- rme_div.sv
module rme_div
   import rme_pkg::*;
#(
   parameter int DIV = DELAY_DIV
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_clr,
   output logic      o_tick
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_q;

   // Free count, realigned on restart
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else if (i_clr) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
         o_tick <= (cnt_q == LAST);
      end
   end
endmodule

//--- rme_dccal.sv
module rme_dccal
   import rme_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire rme_gt_s    i_gt,
   input  wire logic [6:0] i_max,
   output logic            o_run,
   output logic [6:0]      o_src_index
);
   logic [6:0] last_idx_q;
   logic [3:0] last_stage_q;
   logic       have_q;
   logic       in_range;
   logic       reuse;

   // Index must not pass the highest calibrated index
   assign in_range = (i_gt.index <= i_max);
   assign reuse    = have_q && !i_gt.cal_flag && in_range
                     && (i_gt.front_stage == last_stage_q)
                     && (i_gt.index > last_idx_q);

   // Remember flagged index and pick correction source
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         last_idx_q   <= '0;
         last_stage_q <= '0;
         have_q       <= 1'b0;
         o_run        <= 1'b0;
         o_src_index  <= '0;
      end else begin
         o_run <= i_gt.cal_flag && in_range;
         if (i_gt.cal_flag && in_range) begin
            last_idx_q   <= i_gt.index;
            last_stage_q <= i_gt.front_stage;
            have_q       <= 1'b1;
            o_src_index  <= i_gt.index;
         end else begin
            o_src_index  <= reuse ? last_idx_q : i_gt.index;
         end
      end
   end
endmodule

//--- rme_top.sv
module rme_top
   import rme_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [9:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   input  wire logic        i_gain_unlock_pin,
   input  wire logic        i_agc_gain_lock,
   input  wire logic        i_rx_enter,
   input  wire logic        i_gain_change,
   input  wire rme_gt_s     i_gt,
   input  wire logic [8:0]  i_rx_gain_q,
   input  wire logic        i_samp_valid,
   input  wire logic [8:0]  i_samp_level,
   input  wire logic        i_rx_fir_active,
   output logic             o_lna1_output_pin,
   output logic             o_lna2_output_pin,
   output logic             o_peak_det_en,
   output logic             o_rssi_fir_en,
   output logic [1:0]       o_rssi_decim_log2,
   output logic             o_dc_cal_run,
   output logic [6:0]       o_dc_src_index,
   output rme_result_s      o_result,
   output logic             o_rssi_update
);
   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] dur_lo_q;
   logic [7:0] dur_hi_q;
   logic [7:0] mult_q [4];
   logic [7:0] delay_q;
   logic [7:0] wait_q;
   logic [7:0] cfg_q;
   logic [5:0] ext_hi_q;
   logic [5:0] ext_lo_q;
   logic [7:0] fir_q;
   logic [6:0] maxidx_q;
   logic [7:0] pkwait_q;
   logic       wr_trig;
   logic       pow2;
   logic [2:0] sel;

   assign pow2    = cfg_q[CFG_POW2];
   assign sel     = cfg_q[CFG_SEL +: 3];
   // Trigger bit is a write strobe only, never stored
   assign wr_trig = i_reg_wr && (i_reg_addr == A_CFG)
                    && i_reg_wdata[CFG_TRIG];

   // Plain control registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dur_lo_q <= '0;
         dur_hi_q <= '0;
         delay_q  <= '0;
         wait_q   <= '0;
         cfg_q    <= CFG_RST;
         ext_hi_q <= '0;
         ext_lo_q <= '0;
         fir_q    <= '0;
         maxidx_q <= MAXIDX_RST[6:0];
         pkwait_q <= '0;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            A_DUR_LO: dur_lo_q <= i_reg_wdata;
            A_DUR_HI: dur_hi_q <= i_reg_wdata;
            A_DELAY:  delay_q  <= i_reg_wdata;
            A_WAIT:   wait_q   <= i_reg_wdata;
            A_CFG:    cfg_q    <= i_reg_wdata & ~(8'h01 << CFG_TRIG);
            A_EXT_HI: ext_hi_q <= i_reg_wdata[5:0];
            A_EXT_LO: ext_lo_q <= i_reg_wdata[5:0];
            A_FIR:    fir_q    <= i_reg_wdata;
            A_MAXIDX: maxidx_q <= i_reg_wdata[6:0];
            A_PKWAIT: pkwait_q <= i_reg_wdata;
            default:  ;
         endcase
      end
   end

   // Weight multipliers, forced while pow2 mode is on
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mult_q[0] <= W_FULL;
         mult_q[1] <= W_NONE;
         mult_q[2] <= W_NONE;
         mult_q[3] <= W_NONE;
      end else if (pow2) begin
         mult_q[0] <= W_FULL;
         mult_q[1] <= W_NONE;
         mult_q[2] <= W_NONE;
         mult_q[3] <= W_NONE;
      end else if (i_reg_wr && i_reg_addr >= A_MULT0
                   && i_reg_addr <= A_MULT3) begin
         mult_q[2'(i_reg_addr - A_MULT0)] <= i_reg_wdata;
      end
   end

   // Registered read port, unmapped reads give zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            A_DUR_LO: o_reg_rdata <= dur_lo_q;
            A_DUR_HI: o_reg_rdata <= dur_hi_q;
            10'h152:  o_reg_rdata <= mult_q[0];
            10'h153:  o_reg_rdata <= mult_q[1];
            10'h154:  o_reg_rdata <= mult_q[2];
            A_MULT3:  o_reg_rdata <= mult_q[3];
            A_DELAY:  o_reg_rdata <= delay_q;
            A_WAIT:   o_reg_rdata <= wait_q;
            A_CFG:    o_reg_rdata <= cfg_q;
            A_EXT_HI: o_reg_rdata <= {2'h0, ext_hi_q};
            A_EXT_LO: o_reg_rdata <= {2'h0, ext_lo_q};
            A_FIR:    o_reg_rdata <= fir_q;
            A_MAXIDX: o_reg_rdata <= {1'h0, maxidx_q};
            A_PKWAIT: o_reg_rdata <= pkwait_q;
            A_PRE:    o_reg_rdata <= o_result.pre[8:1];
            A_SYM:    o_reg_rdata <= o_result.sym[8:1];
            A_LSB:    o_reg_rdata <= {6'h0, o_result.pre[0],
                                      o_result.sym[0]};
            default:  o_reg_rdata <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Unlock pin synchroniser and restart selection
   // ---------------------------------------------------------------
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;
   logic pin_lvl_q;
   logic pin_rise;
   logic restart;
   logic gain_restart;

   // Three stages; level accepted once stages two and three agree
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_s1_q  <= 1'b0;
         pin_s2_q  <= 1'b0;
         pin_s3_q  <= 1'b0;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_s1_q <= i_gain_unlock_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q == pin_s3_q) begin
            pin_lvl_q <= pin_s3_q;
         end
      end
   end

   assign pin_rise = (pin_s2_q == pin_s3_q) && pin_s3_q && !pin_lvl_q;

   // Event picked by the selector
   always_comb begin
      gain_restart = 1'b0;
      case (sel)
         SEL_AGC:  restart = i_agc_gain_lock;
         SEL_PIN:  restart = pin_rise;
         SEL_RX:   restart = i_rx_enter;
         SEL_GAIN: begin
            restart      = i_gain_change;
            gain_restart = i_gain_change;
         end
         SEL_WR:   restart = wr_trig;
         SEL_GPIN: begin
            restart      = i_gain_change || pin_rise;
            gain_restart = i_gain_change;
         end
         default:  restart = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Source selection and gain compensation
   // ---------------------------------------------------------------
   logic [1:0]  fir_sel;
   logic [1:0]  decim_log2;
   logic [1:0]  dec_cnt_q;
   logic [1:0]  dec_mask;
   logic        take;
   logic [6:0]  ext_q;
   logic [10:0] comp_wide;
   logic [8:0]  comp;

   assign fir_sel = fir_q[FIR_SEL +: 2];
   // Active path FIR forces full rate; otherwise selector decides
   assign decim_log2 = i_rx_fir_active ? 2'd0 :
                       (fir_sel == 2'd2) ? 2'd1 :
                       (fir_sel == 2'd3) ? 2'd2 : 2'd0;
   assign dec_mask = (decim_log2 == 2'd2) ? 2'd3 :
                     (decim_log2 == 2'd1) ? 2'd1 : 2'd0;
   assign take     = i_samp_valid && ((dec_cnt_q & dec_mask) == 2'd0);

   // FIR routing outputs and decimation phase
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rssi_fir_en     <= 1'b0;
         o_rssi_decim_log2 <= '0;
         dec_cnt_q         <= '0;
      end else begin
         o_rssi_fir_en     <= i_rx_fir_active || (fir_sel != 2'd0);
         o_rssi_decim_log2 <= decim_log2;
         if (restart) begin
            dec_cnt_q <= '0;
         end else if (i_samp_valid) begin
            dec_cnt_q <= dec_cnt_q + 2'd1;
         end
      end
   end

   // Half-dB amp gain doubled to quarter-dB, then added to path gain
   assign ext_q     = i_gt.ext_lna[0] ? {ext_hi_q, 1'b0}
                                      : {ext_lo_q, 1'b0};
   assign comp_wide = {2'h0, i_samp_level} + {2'h0, i_rx_gain_q}
                      + {4'h0, ext_q};
   assign comp      = (comp_wide > 11'h1ff) ? 9'h1ff : comp_wide[8:0];

   // ---------------------------------------------------------------
   // Measurement sequencer
   // ---------------------------------------------------------------
   rme_state_e  state_q;
   logic [7:0]  dly_cnt_q;
   logic [7:0]  wait_cnt_q;
   logic [1:0]  seg_q;
   logic [15:0] cnt_q;
   logic [23:0] acc_q;
   logic [18:0] wacc_q;
   logic [3:0]  dur;
   logic [15:0] seg_len;
   logic [23:0] acc_d;
   logic [8:0]  avg;
   logic [18:0] wacc_d;
   logic [19:0] res_wide;
   logic        seg_end;
   logic        meas_done;
   logic        div_tick;

   rme_div #(
      .DIV    (DELAY_DIV)
   ) u_div (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_clr  (restart),
      .o_tick (div_tick)
   );

   // Segment length is two to the power of its field
   always_comb begin
      case (seg_q)
         2'd0:    dur = dur_lo_q[3:0];
         2'd1:    dur = dur_lo_q[7:4];
         2'd2:    dur = dur_hi_q[3:0];
         default: dur = dur_hi_q[7:4];
      endcase
   end

   assign seg_len   = 16'h0001 << dur;
   assign seg_end   = (state_q == ST_MEAS) && take
                      && (cnt_q == seg_len - 16'h0001);
   assign acc_d     = acc_q + {15'h0, comp};
   assign avg       = 9'(acc_d >> dur);
   assign wacc_d    = wacc_q + 19'(avg * mult_q[seg_q]);
   assign meas_done = seg_end && (pow2 || seg_q == 2'd3);
   // Divide the weighted sum by 255, rounding down
   assign res_wide  = ({1'b0, wacc_d} + 20'(wacc_d >> 8) + 20'h1) >> 8;

   // Delay, measure, wait cycle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q    <= ST_DELAY;
         dly_cnt_q  <= '0;
         wait_cnt_q <= '0;
      end else if (restart) begin
         state_q    <= ST_DELAY;
         dly_cnt_q  <= delay_q;
      end else begin
         case (state_q)
            ST_DELAY: begin
               if (div_tick) begin
                  if (dly_cnt_q == 8'h00) begin
                     state_q <= ST_MEAS;
                  end else begin
                     dly_cnt_q <= dly_cnt_q - 8'h01;
                  end
               end
            end
            ST_MEAS: begin
               if (meas_done) begin
                  if (wait_q == 8'h00) begin
                     state_q <= ST_MEAS;
                  end else begin
                     state_q    <= ST_WAIT;
                     wait_cnt_q <= wait_q;
                  end
               end
            end
            ST_WAIT: begin
               if (wait_cnt_q <= 8'h01) begin
                  state_q <= ST_MEAS;
               end else begin
                  wait_cnt_q <= wait_cnt_q - 8'h01;
               end
            end
            default: state_q <= ST_DELAY;
         endcase
      end
   end

   // Sample counter and accumulators
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         seg_q  <= '0;
         cnt_q  <= '0;
         acc_q  <= '0;
         wacc_q <= '0;
      end else if (restart || state_q != ST_MEAS) begin
         seg_q  <= '0;
         cnt_q  <= '0;
         acc_q  <= '0;
         wacc_q <= '0;
      end else if (seg_end) begin
         cnt_q <= '0;
         acc_q <= '0;
         if (meas_done) begin
            seg_q  <= '0;
            wacc_q <= '0;
         end else begin
            seg_q  <= seg_q + 2'd1;
            wacc_q <= wacc_d;
         end
      end else if (take) begin
         cnt_q <= cnt_q + 16'h0001;
         acc_q <= acc_d;
      end
   end

   // ---------------------------------------------------------------
   // Results
   // ---------------------------------------------------------------
   logic first_q;
   logic by_gain_q;
   logic [8:0] res;

   assign res = (res_wide > 20'h1ff) ? 9'h1ff : res_wide[8:0];

   // Preamble holds first result after a restart not caused by a gain change, symbol tracks every result
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         first_q       <= 1'b1;
         by_gain_q     <= 1'b0;
         o_result      <= '0;
         o_rssi_update <= 1'b0;
      end else begin
         o_rssi_update <= meas_done && !restart;
         if (restart) begin
            first_q   <= 1'b1;
            by_gain_q <= gain_restart;
         end else if (meas_done) begin
            o_result.sym <= res;
            first_q      <= 1'b0;
            if (first_q && !by_gain_q) begin
               o_result.pre <= res;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Peak detector hold-off
   // ---------------------------------------------------------------
   logic [7:0] pk_cnt_q;
   logic [7:0] pk_cnt_d;

   assign pk_cnt_d = i_gain_change ? pkwait_q :
                     (pk_cnt_q != 8'h00) ? pk_cnt_q - 8'h01 : 8'h00;

   // Detectors stay off while the hold-off runs
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pk_cnt_q      <= '0;
         o_peak_det_en <= 1'b1;
      end else begin
         pk_cnt_q      <= pk_cnt_d;
         o_peak_det_en <= !i_gain_change && (pk_cnt_d == 8'h00);
      end
   end

   // ---------------------------------------------------------------
   // External amplifier pins
   // ---------------------------------------------------------------
   // Table bits drive the pins only when routing is enabled
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lna1_output_pin <= 1'b0;
         o_lna2_output_pin <= 1'b0;
      end else begin
         o_lna1_output_pin <= fir_q[FIR_LNA1] && i_gt.ext_lna[0];
         o_lna2_output_pin <= fir_q[FIR_LNA2] && i_gt.ext_lna[1];
      end
   end

   // ---------------------------------------------------------------
   // Offset calibration index mapping
   // ---------------------------------------------------------------
   rme_dccal u_dccal (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_gt        (i_gt),
      .i_max       (maxidx_q),
      .o_run       (o_dc_cal_run),
      .o_src_index (o_dc_src_index)
   );
endmodule

//--- rme_top_sva.sv
module rme_chk
   import rme_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_gain_change,
   input  wire rme_gt_s     i_gt,
   input  wire logic        i_samp_valid,
   input  wire logic        i_rx_fir_active,
   input  wire logic        o_lna1_output_pin,
   input  wire logic        o_lna2_output_pin,
   input  wire logic        o_peak_det_en,
   input  wire logic        o_rssi_fir_en,
   input  wire logic [1:0]  o_rssi_decim_log2,
   input  wire logic        o_dc_cal_run,
   input  wire logic [6:0]  o_dc_src_index,
   input  wire rme_result_s o_result,
   input  wire logic        o_rssi_update
);
   // Properties on the sample clock, off during reset
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_lna1; o_lna1_output_pin |-> $past(i_gt.ext_lna[0]); endproperty
   a_lna1: assert property (p_lna1) else $error("lna1 pin without table bit");
   property p_lna2; o_lna2_output_pin |-> $past(i_gt.ext_lna[1]); endproperty
   a_lna2: assert property (p_lna2) else $error("lna2 pin without table bit");
   property p_dc;
      o_dc_cal_run |-> $past(i_gt.cal_flag) && o_dc_src_index == $past(i_gt.index);
   endproperty
   a_dc: assert property (p_dc) else $error("offset cal at unflagged index");
   property p_fir; $past(i_nrst) && $past(i_rx_fir_active) |-> o_rssi_fir_en; endproperty
   a_fir: assert property (p_fir) else $error("active path filter not used");
   property p_peak; i_gain_change |=> !$rose(o_peak_det_en); endproperty
   a_peak: assert property (p_peak) else $error("peak detect on at gain change");
   property p_decim;
      o_rssi_decim_log2 != 2'h0 |-> o_rssi_fir_en && o_rssi_decim_log2 != 2'h3;
   endproperty
   a_decim: assert property (p_decim) else $error("decimation without filter");
   property p_pre;
      $changed(o_result.pre) |-> o_rssi_update && o_result.pre == o_result.sym;
   endproperty
   a_pre: assert property (p_pre) else $error("preamble loaded apart from symbol");
   property p_sym; $changed(o_result.sym) |-> o_rssi_update; endproperty
   a_sym: assert property (p_sym) else $error("symbol changed without update");
   property p_upd; o_rssi_update |-> $past(i_samp_valid); endproperty
   a_upd: assert property (p_upd) else $error("update without sample");
endmodule
bind rme_top rme_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_gain_change(i_gain_change),
   .i_gt(i_gt), .i_samp_valid(i_samp_valid), .i_rx_fir_active(i_rx_fir_active),
   .o_lna1_output_pin(o_lna1_output_pin), .o_lna2_output_pin(o_lna2_output_pin),
   .o_peak_det_en(o_peak_det_en), .o_rssi_fir_en(o_rssi_fir_en),
   .o_rssi_decim_log2(o_rssi_decim_log2), .o_dc_cal_run(o_dc_cal_run),
   .o_dc_src_index(o_dc_src_index), .o_result(o_result), .o_rssi_update(o_rssi_update));

//--- rme_host.sv
module rme_host
   import rme_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic [9:0]      o_addr,
   output logic [7:0]      o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 10'h000;
      o_wdata = 8'h00;
   end
   // One write, strobe held for one sampling edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   // One read, data taken after the edge that took it
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask
   // Amp gains in half dB, negative low gain folded into high
   task automatic ext_gain(input int hi, input int lo);
      if (lo < 0) begin
         hi = hi - lo;
         lo = 0;
      end
      wr(A_EXT_HI, 8'(hi));
      wr(A_EXT_LO, 8'(lo));
   endtask
endmodule

//--- rssi_measurement_engine_bench.sv
module rssi_measurement_engine_bench
   import rme_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        fa;
      logic [7:0]  fir;
      rme_gt_s     gt;
      logic [12:0] e;
   } rme_row_s;
   logic        clk, nrst, wr, rd, pin, lock, rxe, gch, sv, fa, lna1, lna2, pk, fen, upd, run;
   logic [9:0]  addr;
   logic [7:0]  wdata, rdata, d;
   logic [8:0]  lvl, epre, esym, rxg;
   logic [1:0]  dec;
   logic [6:0]  src;
   rme_gt_s     gt;
   rme_result_s res;
   int          n_mismatch = 0;
   int          n_checks = 0;
   // Filter select, table entry, expected {pins, fir, decim, cal run, src}
   rme_row_s rows [6] = '{{1'b0, 8'h00, 7'h05, 1'b1, 4'h3, 2'h3, 13'h0085},
      {1'b0, 8'h31, 7'h06, 1'b0, 4'h3, 2'h3, 13'h1c05}, {1'b0, 8'h12, 7'h07, 1'b1, 4'h4, 2'h1, 13'h1587},
      {1'b0, 8'h33, 7'h08, 1'b1, 4'h4, 2'h2, 13'h0e88}, {1'b0, 8'h03, 7'h76, 1'b1, 4'h5, 2'h3, 13'h06f6},
      {1'b1, 8'h00, 7'h76, 1'b1, 4'h5, 2'h0, 13'h04f6}};
   rme_top dut (.i_clk(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_gain_unlock_pin(pin), .i_agc_gain_lock(lock),
      .i_rx_enter(rxe), .i_gain_change(gch), .i_gt(gt), .i_rx_gain_q(rxg), .i_samp_valid(sv),
      .i_samp_level(lvl), .i_rx_fir_active(fa), .o_lna1_output_pin(lna1),
      .o_lna2_output_pin(lna2), .o_peak_det_en(pk), .o_rssi_fir_en(fen),
      .o_rssi_decim_log2(dec), .o_dc_cal_run(run), .o_dc_src_index(src), .o_result(res),
      .o_rssi_update(upd));
   rme_host host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata));
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
      n_checks++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Sample clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
   // Main sequence
   initial begin
      {nrst, pin, lock, rxe, gch, fa} = 6'h00;
      sv = 1'b1;
      lvl = 9'h000;
      rxg = 9'h000;
      gt = '0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      host.rd(A_MAXIDX, d); chk("maxidx", MAXIDX_RST, d);
      host.rd(A_CFG, d); chk("cfg", CFG_RST, d);
      host.rd(A_MULT0, d); chk("mult0", W_FULL, d);
      host.rd(A_MULT3, d); chk("mult3", W_NONE, d);
      foreach (rows[i]) begin
         @(posedge clk);
         fa <= rows[i].fa;
         gt <= rows[i].gt;
         host.wr(A_FIR, rows[i].fir);
         repeat (2) @(posedge clk);
         #1 chk("pins", rows[i].e, {lna1, lna2, fen, dec, run, src});
      end
      // Peak hold-off after a gain change with no restart
      host.wr(A_PKWAIT, 8'h04);
      host.ext_gain(6, -4);
      @(posedge clk);
      gch <= 1'b1;
      gt <= {7'h76, 1'b1, 4'h5, 2'h1};
      @(posedge clk);
      gch <= 1'b0;
      @(posedge clk);
      #1 chk("peak_hold", 18'h0, pk);
      repeat (8) @(posedge clk);
      #1 chk("peak_back", 18'h1, pk);
      // Every restart selector with its own event
      for (int s = 0; s < 6; s++) begin
         host.wr(A_CFG, 8'h01 | 8'(s << 2));
         @(posedge clk);
         lvl <= 9'(41 + 8 * s);
         case (s)
            0: lock <= 1'b1;
            1: pin <= 1'b1;
            2: rxe <= 1'b1;
            3, 5: gch <= 1'b1;
            default: ;
         endcase
         if (s == 4) host.wr(A_CFG, 8'h31);
         @(posedge clk);
         {lock, rxe, gch} <= 3'b000;
         esym = 9'(61 + 8 * s);
         if (s != 3 && s != 5) epre = esym;
         for (int k = 0; k < 80 && (res.pre !== epre || res.sym !== esym); k++) @(posedge clk);
         #1 chk("pre", epre, res.pre);
         chk("sym", esym, res.sym);
         @(posedge clk);
         pin <= 1'b0;
      end
      host.rd(A_SYM, d); chk("sym_reg", esym[8:1], d);
      host.rd(A_PRE, d); chk("pre_reg", epre[8:1], d);
      host.rd(A_LSB, d); chk("lsb_reg", {6'h00, epre[0], esym[0]}, d);
      host.rd(10'h3ff, d); chk("unmapped", 18'h0, d);
      // Four segments of 1, 2, 1 and 1 samples, three wait cycles between periods
      host.wr(A_CFG, 8'h10);
      host.wr(A_DUR_LO, 8'h10);
      host.wr(A_WAIT, 8'h03);
      for (int m = 0; m < 4; m++) begin
         host.wr(A_MULT0 + 10'(m), (m == 1) ? 8'h66 : 8'h33);
      end
      host.rd(A_MULT0 + 10'h1, d); chk("mult1", 18'h66, d);
      @(posedge clk);
      lvl <= 9'hb4;
      rxg <= 9'h14;
      host.wr(A_CFG, 8'h30);
      #1;
      for (int k = 0; k < 80 && (res.pre !== 9'hdc || upd !== 1'b1); k++) begin
         @(posedge clk);
         #1;
      end
      chk("pre_4seg", 18'hdc, res.pre);
      repeat (7) @(posedge clk);
      #1 chk("upd_gap", 18'h0, upd);
      @(posedge clk);
      #1 chk("upd_next", 18'h1, upd);
      chk("sym_4seg", 18'hdc, res.sym);
      // Reset in mid-run
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      #1 chk("rst_result", 18'h0, res);
      chk("rst_peak", 18'h1, pk);
      @(posedge clk);
      nrst <= 1'b1;
      host.rd(A_CFG, d); chk("rst_cfg", CFG_RST, d);
      summarize();
   end
endmodule
